// ===== shared/alss_consts.svh
// constants of the antenna link slot scheduler
// Function
// [R1] modulo of zero bypasses modulo allocation; bit map rule alone schedules
// [R2] group count of zero bypasses bit map rule; modulo alone applies
// [R3] both active: one slot per modulo count, split by group count
// [R4] bit map inserts bubble slots for non-integer ratios, e.g. X=3 map 001
// [R5] integer ratio four: X=4 with map 0, or modulo four
// [R6] OBSAI send uses both rules; CPRI bit map only; OBSAI receive none
// [R7] 64 rule entries; control and antenna slots use different modulo entries
// [R8] OBSAI receive channel takes a message only on type and address match
// [R9] OBSAI transmitter gives each channel distinct header information
// [R10] CPRI both ends use identical predefined bit map positions per stream
// [R11] sixteen streams into 4x CPRI: X=16 with one-entry map zero
// [R12] lookup RAM of 64x64 entries, OBSAI indexed by rule then channel
// [R13] CPRI views lookup RAM as 8x512, link below six, channel below 64
// [R14] two counter levels: packet size and packets per frame; six sets
// [R15] units: OBSAI message; CPRI 4 bytes transmit, 16 bytes receive
// [R16] each channel picks one of six structures; change on frame boundary
// [R17] channel offset from frame timer boundary delays counting and transfer
// [R18] CPRI receive offset counts from received sync boundary, normally zero
// [R19] duplex gating only on packet DMA path, active slots only
// [R20] gated transmit sends a symbol only when a packet arrived
// [R21] feeder enqueues only active-slot packets, one packet ahead
// [R22] receive bit map per channel: one keeps packet, zero drops it
// [R23] structure written mid-frame takes effect at next frame boundary
`ifndef ALSS_CONSTS_SVH
`define ALSS_CONSTS_SVH
`define ALSS_OFF_CTRL  15'h0000
`define ALSS_OFF_STAT  15'h0004
`define ALSS_PG_CTRL   7'h00
`define ALSS_PG_RULE   7'h01
`define ALSS_PG_FS     7'h02
`define ALSS_PG_CH     7'h03
`define ALSS_PG_MAP    7'h04
`define ALSS_N_RULE    64
`define ALSS_N_CH      64
`define ALSS_N_FS      6
`define ALSS_FS_LAST   3'h5
`define ALSS_N_LUT     4096
`define ALSS_RX_QUAD   2'h3
`endif

// ===== shared/alss_pkg.sv
// types of the antenna link slot scheduler
package alss_pkg;
    typedef struct packed {
        logic        valid;
        logic [4:0]  htype;
        logic [12:0] haddr;
    } alss_rx_in_s;
    typedef struct packed {
        logic       valid;
        logic       bubble;
        logic [5:0] chan;
        logic       sop;
        logic       eop;
    } alss_tx_out_s;
    typedef struct packed {
        logic       valid;
        logic       drop;
        logic [5:0] chan;
        logic       sop;
        logic       eop;
    } alss_rx_out_s;
    typedef struct packed {
        logic        run;
        logic [10:0] off;
        logic [11:0] ucnt;
        logic [7:0]  pidx;
        logic        sop;
        logic        eop;
    } alss_frm_s;
    typedef struct packed {
        logic [5:0] grp;
        logic [3:0] mi;
        logic       bub;
        logic [5:0] ch;
        logic       isb;
    } alss_bmap_s;
endpackage

// ===== core/alss_core.sv
// slot scheduler, framing counters and duplex gating with AHB-Lite registers
`timescale 1ns/1ps
`include "alss_consts.svh"
module alss_core (
    input  wire logic                  clock,
    input  wire logic                  rstn,
    input  wire logic                  hsel,
    input  wire logic [31:0]           haddr,
    input  wire logic [1:0]            htrans,
    input  wire logic                  hwrite,
    input  wire logic [2:0]            hsize,
    input  wire logic [31:0]           hwdata,
    input  wire logic                  hready,
    output logic                       hreadyout,
    output logic                       hresp,
    output logic [31:0]                hrdata,
    input  wire logic                  slot_tick,
    input  wire logic                  pkt_avail,
    input  wire logic                  frame_tick,
    input  wire logic                  rx_sync_tick,
    input  wire alss_pkg::alss_rx_in_s rx_in,
    output alss_pkg::alss_tx_out_s     tx_out,
    output alss_pkg::alss_rx_out_s     rx_out
);
    import alss_pkg::*;

    // ----------------------------------------
    // storage
    // ----------------------------------------
    logic [31:0] rule_q  [`ALSS_N_RULE]; // R7
    logic [31:0] fs_q    [`ALSS_N_FS]; // R14
    logic [31:0] chcfg_q [`ALSS_N_CH];
    logic [31:0] rxmap_q [`ALSS_N_CH];
    logic [2:0]  fs_act_q[`ALSS_N_CH];
    logic [5:0]  lut_q   [`ALSS_N_LUT]; // R12
    alss_frm_s   tx_frm_q[`ALSS_N_CH];
    alss_frm_s   rx_frm_q[`ALSS_N_CH];

    logic        cpri_q;
    logic        tdd_tx_q;
    logic        tdd_rx_q;
    logic        dio_q;
    logic [2:0]  link_q;
    logic [5:0]  trule_q;
    logic [15:0] tx_cnt_q;
    logic [15:0] rx_cnt_q;

    // ----------------------------------------
    // functions
    // ----------------------------------------
    function automatic logic [11:0] lut_ix(input logic       cp,
                                           input logic [2:0] lk,
                                           input logic [5:0] ru,
                                           input logic [5:0] ch);
        // cpri view is link*512+channel, obsai rule*64+channel
        lut_ix = cp ? {lk, 3'h0, ch} : {ru, ch}; // R12 R13
    endfunction

    function automatic alss_bmap_s bmap_step(input alss_bmap_s  s,
                                             input logic [31:0] r);
        alss_bmap_s  n;
        logic [15:0] m;
        n = s;
        m = r[31:16];
        n.isb = 1'b0;
        n.ch = 6'h00;
        if (r[11:6] == 6'h00) begin
            n.ch = 6'h00; // R2
        end else if (s.bub) begin
            n.isb = 1'b1; // R4
            n.bub = 1'b0;
        end else begin
            n.ch = s.grp; // R5 R11
            if (s.grp == r[11:6] - 6'h01) begin
                n.grp = 6'h00;
                n.bub = m[s.mi]; // R4
                n.mi = (s.mi == r[15:12]) ? 4'h0 : s.mi + 4'h1;
            end else begin
                n.grp = s.grp + 6'h01;
            end
        end
        return n;
    endfunction

    function automatic alss_frm_s frm_step(input alss_frm_s   s,
                                           input logic [31:0] f,
                                           input logic [10:0] ofs);
        alss_frm_s   n;
        logic [11:0] sz;
        n = s;
        n.sop = 1'b0;
        n.eop = 1'b0;
        sz = (s.pidx == 8'h00) ? f[11:0] : f[23:12];
        if (!s.run && s.off < ofs) begin
            n.off = s.off + 11'h001; // R17 R18
        end else begin
            n.run = 1'b1;
            n.sop = (s.ucnt == 12'h000);
            if (s.ucnt == sz - 12'h001) begin
                n.eop = 1'b1; // R14
                n.ucnt = 12'h000;
                n.pidx = (s.pidx == f[31:24] - 8'h01) ? 8'h00
                                                      : s.pidx + 8'h01;
            end else begin
                n.ucnt = s.ucnt + 12'h001;
            end
        end
        return n;
    endfunction

    function automatic logic [31:0] fsw(input logic [2:0] sel);
        // illegal selections fold onto the last structure
        fsw = fs_q[(sel > `ALSS_FS_LAST) ? `ALSS_FS_LAST : sel]; // R16
    endfunction

    function automatic logic [6:0] find_ch(input logic [4:0]  ty,
                                           input logic [12:0] ad);
        logic [6:0] v;
        v = 7'h00;
        for (int i = `ALSS_N_CH - 1; i >= 0; i--) begin
            if (chcfg_q[i][7:3] == ty && chcfg_q[i][20:8] == ad) begin
                v = {1'b1, 6'(i)}; // R8
            end
        end
        return v;
    endfunction

    function automatic logic [31:0] rd_word(input logic [14:0] a);
        logic [31:0] v;
        v = 32'h0000_0000;
        if (a[14]) begin
            v = {26'h000_0000, lut_q[a[13:2]]};
        end else begin
            case (a[14:8])
                `ALSS_PG_CTRL: begin
                    if (a == `ALSS_OFF_CTRL) begin
                        v = {18'h0_0000, trule_q, 1'b0, link_q,
                             dio_q, tdd_rx_q, tdd_tx_q, cpri_q};
                    end else if (a == `ALSS_OFF_STAT) begin
                        v = {rx_cnt_q, tx_cnt_q};
                    end
                end
                `ALSS_PG_RULE: v = rule_q[a[7:2]];
                `ALSS_PG_FS: begin
                    if (a[7:5] == 3'h0 && a[4:2] <= `ALSS_FS_LAST) begin
                        v = fs_q[a[4:2]];
                    end
                end
                `ALSS_PG_CH:  v = chcfg_q[a[7:2]];
                `ALSS_PG_MAP: v = rxmap_q[a[7:2]];
                default:      v = 32'h0000_0000;
            endcase
        end
        return v;
    endfunction

    // ----------------------------------------
    // bus slave
    // ----------------------------------------
    logic        a_wr_q;
    logic [14:0] a_ad_q;
    logic [31:0] hrdata_q;
    logic        take;
    logic        wr;

    // zero wait states: read data is looked up in the address phase
    assign take = hsel & htrans[1] & hready & (haddr[31:15] == 17'h0_0000);
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;
    assign wr = a_wr_q;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            a_wr_q <= 1'b0;
            a_ad_q <= 15'h0000;
            hrdata_q <= 32'h0000_0000;
        end else begin
            a_wr_q <= take & hwrite;
            a_ad_q <= haddr[14:0];
            hrdata_q <= (take & ~hwrite) ? rd_word(haddr[14:0])
                                         : 32'h0000_0000;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            cpri_q <= 1'b0;
            tdd_tx_q <= 1'b0;
            tdd_rx_q <= 1'b0;
            dio_q <= 1'b0;
            link_q <= 3'h0;
            trule_q <= 6'h00;
        end else if (wr && a_ad_q == `ALSS_OFF_CTRL) begin
            cpri_q <= hwdata[0];
            tdd_tx_q <= hwdata[1];
            tdd_rx_q <= hwdata[2];
            dio_q <= hwdata[3];
            link_q <= hwdata[6:4];
            trule_q <= hwdata[13:8];
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            for (int i = 0; i < `ALSS_N_RULE; i++) begin
                rule_q[i] <= 32'h0000_0000;
            end
        end else if (wr && !a_ad_q[14] && a_ad_q[14:8] == `ALSS_PG_RULE) begin
            rule_q[a_ad_q[7:2]] <= hwdata;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            for (int i = 0; i < `ALSS_N_FS; i++) begin
                fs_q[i] <= 32'h0000_0000;
            end
        end else if (wr && a_ad_q[14:8] == `ALSS_PG_FS && a_ad_q[7:5] == 3'h0
                     && a_ad_q[4:2] <= `ALSS_FS_LAST) begin
            fs_q[a_ad_q[4:2]] <= hwdata;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            for (int i = 0; i < `ALSS_N_CH; i++) begin
                chcfg_q[i] <= 32'h0000_0000;
                rxmap_q[i] <= 32'h0000_0000;
            end
        end else if (wr && a_ad_q[14:8] == `ALSS_PG_CH) begin
            chcfg_q[a_ad_q[7:2]] <= hwdata;
        end else if (wr && a_ad_q[14:8] == `ALSS_PG_MAP) begin
            rxmap_q[a_ad_q[7:2]] <= hwdata;
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            for (int i = 0; i < `ALSS_N_LUT; i++) begin
                lut_q[i] <= 6'h00;
            end
        end else if (wr && a_ad_q[14]) begin
            lut_q[a_ad_q[13:2]] <= hwdata[5:0]; // R12
        end
    end

    // ----------------------------------------
    // frame structure selection
    // ----------------------------------------
    // the written selection waits in the channel word until a boundary
    always_ff @(posedge clock) begin
        if (!rstn) begin
            for (int i = 0; i < `ALSS_N_CH; i++) begin
                fs_act_q[i] <= 3'h0;
            end
        end else if (frame_tick) begin
            for (int i = 0; i < `ALSS_N_CH; i++) begin
                fs_act_q[i] <= chcfg_q[i][2:0]; // R16 R23
            end
        end
    end

    // ----------------------------------------
    // transmit encoder
    // ----------------------------------------
    logic [5:0]  tmc_q;
    alss_bmap_s  tdbm_q;
    alss_bmap_s  tdbm_n;
    alss_frm_s   tfn;
    alss_tx_out_s tx_q;
    logic [31:0] trw;
    logic [5:0]  tmod;
    logic [5:0]  tch;
    logic        thit;
    logic        tgo;
    logic        tsend;
    logic        tbub;

    assign trw = rule_q[cpri_q ? {3'h0, link_q} : trule_q];
    assign tmod = cpri_q ? 6'h00 : trw[5:0]; // R6
    assign thit = (tmod == 6'h00) | (tmc_q == 6'h00); // R1 R3
    assign tdbm_n = bmap_step(tdbm_q, trw);
    assign tch = lut_q[lut_ix(cpri_q, link_q, trule_q, tdbm_n.ch)];
    assign tfn = frm_step(tx_frm_q[tch], fsw(fs_act_q[tch]),
                          chcfg_q[tch][31:21]);
    assign tbub = slot_tick & thit & tdbm_n.isb; // R4
    // gating holds off symbols until the packet DMA delivered one
    assign tgo = slot_tick & thit & ~tdbm_n.isb
               & (~(tdd_tx_q & ~dio_q) | pkt_avail); // R19 R20
    assign tsend = tgo & tfn.run; // R17
    assign tx_out = tx_q;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            tmc_q <= 6'h00;
            tdbm_q <= '0;
        end else if (slot_tick) begin
            tmc_q <= (tmod == 6'h00 || tmc_q == tmod - 6'h01)
                     ? 6'h00 : tmc_q + 6'h01; // R3
            if (thit) begin
                tdbm_q <= tdbm_n;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn || frame_tick) begin
            for (int i = 0; i < `ALSS_N_CH; i++) begin
                tx_frm_q[i] <= '0; // R17
            end
        end else if (tgo) begin
            tx_frm_q[tch] <= tfn; // R15 R14
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            tx_q <= '0;
            tx_cnt_q <= 16'h0000;
        end else begin
            tx_q.valid <= tsend | tbub;
            tx_q.bubble <= tbub;
            tx_q.chan <= tch;
            tx_q.sop <= tsend & tfn.sop;
            tx_q.eop <= tsend & tfn.eop;
            if (tsend) begin
                tx_cnt_q <= tx_cnt_q + 16'h0001;
            end
        end
    end

    // ----------------------------------------
    // receive decoder
    // ----------------------------------------
    logic [1:0]  rq4_q;
    alss_bmap_s  rdbm_q;
    alss_bmap_s  rdbm_n;
    alss_frm_s   rfn;
    alss_rx_out_s rx_q;
    logic [6:0]  rmatch;
    logic [5:0]  rch;
    logic [7:0]  rpi;
    logic        runit;
    logic        rok;
    logic        rkeep;
    logic        rbnd;

    // cpri receive counts sixteen-byte units from four-byte words
    assign runit = rx_in.valid
                 & (~cpri_q | rq4_q == `ALSS_RX_QUAD); // R15
    assign rdbm_n = bmap_step(rdbm_q, rule_q[{3'h0, link_q}]);
    assign rmatch = cpri_q
        ? {~rdbm_n.isb, lut_q[lut_ix(1'b1, link_q, 6'h00, rdbm_n.ch)]}
        : find_ch(rx_in.htype, rx_in.haddr); // R6 R8 R10
    assign rch = rmatch[5:0];
    assign rok = runit & rmatch[6];
    assign rfn = frm_step(rx_frm_q[rch], fsw(fs_act_q[rch]),
                          chcfg_q[rch][31:21]);
    assign rpi = rx_frm_q[rch].pidx;
    // only the first 32 packets of a frame have a map bit
    assign rkeep = ~(tdd_rx_q & ~dio_q)
                 | (rpi[7:5] == 3'h0 & rxmap_q[rch][rpi[4:0]]); // R19 R22
    assign rbnd = cpri_q ? rx_sync_tick : frame_tick; // R17 R18
    assign rx_out = rx_q;

    always_ff @(posedge clock) begin
        if (!rstn) begin
            rq4_q <= 2'h0;
            rdbm_q <= '0;
        end else if (rx_in.valid && cpri_q) begin
            rq4_q <= rq4_q + 2'h1;
            if (runit) begin
                rdbm_q <= rdbm_n; // R10
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn || rbnd) begin
            for (int i = 0; i < `ALSS_N_CH; i++) begin
                rx_frm_q[i] <= '0; // R18
            end
        end else if (rok) begin
            rx_frm_q[rch] <= rfn; // R14
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            rx_q <= '0;
            rx_cnt_q <= 16'h0000;
        end else begin
            rx_q.valid <= rok & rfn.run;
            rx_q.drop <= ~rkeep; // R22
            rx_q.chan <= rch;
            rx_q.sop <= rok & rfn.run & rfn.sop;
            rx_q.eop <= rok & rfn.run & rfn.eop;
            if (rok && rfn.run && rkeep) begin
                rx_cnt_q <= rx_cnt_q + 16'h0001;
            end
        end
    end

endmodule

// ===== testbench/alss_core_props.sv
// concurrent checks on the slot scheduler ports
`timescale 1ns/1ps
module alss_core_props (
    input wire logic                  clock,
    input wire logic                  rstn,
    input wire logic                  hsel,
    input wire logic [31:0]           haddr,
    input wire logic [1:0]            htrans,
    input wire logic                  hwrite,
    input wire logic                  hready,
    input wire logic [31:0]           hwdata,
    input wire logic                  hreadyout,
    input wire logic                  hresp,
    input wire logic [31:0]           hrdata,
    input wire logic                  slot_tick,
    input wire logic                  pkt_avail,
    input wire alss_pkg::alss_rx_in_s rx_in,
    input wire alss_pkg::alss_tx_out_s tx_out,
    input wire alss_pkg::alss_rx_out_s rx_out
);
    import alss_pkg::*;
    // ------------------------------------------------------------
    // shadow of the control word, from the bus traffic alone
    // ------------------------------------------------------------
    logic        ap_q;
    logic        wr_q;
    logic [31:0] ad_q;
    logic [31:0] ctl_q;
    logic        txg;
    logic        rxg;
    assign txg = ctl_q[1] & ~ctl_q[3];
    assign rxg = ctl_q[2] & ~ctl_q[3];
    always_ff @(posedge clock) begin
        if (!rstn) begin
            ap_q <= 1'b0;
            wr_q <= 1'b0;
            ad_q <= 32'h0;
        end else begin
            ap_q <= hsel & htrans[1] & hready & (haddr[31:15] == 17'h0);
            wr_q <= hwrite;
            ad_q <= haddr;
        end
    end
    always_ff @(posedge clock) begin
        if (!rstn) begin
            ctl_q <= 32'h0;
        end else if (ap_q && wr_q && ad_q == 32'h0) begin
            ctl_q <= hwdata;
        end
    end
    // ------------------------------------------------------------
    // properties
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);
    sequence s_tick_nopkt;
        slot_tick && !pkt_avail && txg;
    endsequence
    a_tx_after_tick: assert property (tx_out.valid |-> $past(slot_tick))
        else $error("tx output without a slot tick");
    a_gate_no_pkt: assert property (s_tick_nopkt |=>
        (!tx_out.valid || tx_out.bubble))
        else $error("gated data slot sent without a packet");
    a_rx_after_unit: assert property (rx_out.valid |-> $past(rx_in.valid))
        else $error("rx output without an incoming unit");
    a_drop_needs_gate: assert property ((rx_out.valid && rx_out.drop)
        |-> $past(rxg))
        else $error("rx drop while gating is off");
    a_bubble_clean: assert property (tx_out.bubble |->
        tx_out.valid && !tx_out.sop && !tx_out.eop)
        else $error("malformed bubble slot");
    a_rx_marks: assert property ((rx_out.sop || rx_out.eop) |-> rx_out.valid)
        else $error("rx packet mark outside a unit");
    a_rdata_idle: assert property (!(ap_q && !wr_q) |-> hrdata == 32'h0)
        else $error("read data outside a read data phase");
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus response not ready and okay");
endmodule
bind alss_core alss_core_props u_alss_core_props (.clock(clock),
    .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .slot_tick(slot_tick), .pkt_avail(pkt_avail), .rx_in(rx_in),
    .tx_out(tx_out), .rx_out(rx_out));

// ===== testbench/alss_peer.sv
// behavioural peer that sends headed messages over the receive link
`timescale 1ns/1ps
module alss_peer (
    input  wire logic             clock,
    input  wire logic             rstn,
    input  wire logic             req,
    input  wire logic [4:0]       req_type,
    input  wire logic [12:0]      req_addr,
    output alss_pkg::alss_rx_in_s rx_in
);
    import alss_pkg::*;
    // idle header flips each cycle, back to the stale value every other cycle; valid stays low so it never matches
    always_ff @(posedge clock) begin
        if (!rstn) begin
            rx_in <= '0;
        end else if (req) begin
            rx_in <= {1'b1, req_type, req_addr};
        end else begin
            rx_in <= {1'b0, ~rx_in.htype, ~rx_in.haddr};
        end
    end
endmodule

// ===== testbench/alss_core_tb.sv
// self-checking bench for the slot scheduler
`timescale 1ns/1ps
module alss_core_tb;
    import alss_pkg::*;
    logic         clock, rstn, hsel, hwrite, hready, hreadyout, hresp;
    logic         slot_tick, pkt_avail, frame_tick, rx_sync_tick, req;
    logic [31:0]  haddr, hwdata, hrdata;
    logic [1:0]   htrans;
    logic [4:0]   req_type;
    logic [12:0]  req_addr;
    logic [5:0]   channel_lookup_entry [16];
    alss_rx_in_s  rx_in;
    alss_tx_out_s tx_out;
    alss_rx_out_s rx_out;
    int           n_errors, checks, cyc, f;
    assign hready = hreadyout;
    always #50 clock = ~clock;
    alss_core u_alss_core (.clock(clock), .rstn(rstn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
        .hresp(hresp), .hrdata(hrdata), .slot_tick(slot_tick),
        .pkt_avail(pkt_avail), .frame_tick(frame_tick),
        .rx_sync_tick(rx_sync_tick), .rx_in(rx_in), .tx_out(tx_out),
        .rx_out(rx_out));
    alss_peer u_alss_peer (.clock(clock), .rstn(rstn), .req(req),
        .req_type(req_type), .req_addr(req_addr), .rx_in(rx_in));
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic summarize;
        if (n_errors == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [31:0] a,
        input logic [31:0] d, output logic [31:0] r);
        @(posedge clock);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        @(posedge clock);
        while (hready !== 1'b1) @(posedge clock);
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge clock);
        while (hready !== 1'b1) @(posedge clock);
        r = hrdata;
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        logic [31:0] r;
        bus(1'b0, a, 32'h0, r);
        chk(r, e);
    endtask
    task automatic rst;
        rstn <= 1'b0;
        repeat (16) @(posedge clock);
        rstn <= 1'b1;
    endtask
    task automatic frame;
        @(posedge clock);
        frame_tick <= 1'b1;
        @(posedge clock);
        frame_tick <= 1'b0;
    endtask
    // schedule from a fresh reset so modulo and map phases start at zero
    task automatic txrun(input logic [31:0] rule, input logic [31:0] ctl,
        input logic pk, input int m, input int x, input int s,
        input logic [15:0] map, input logic keep, input int n);
        alss_tx_out_s o;
        int i, g, p, c;
        g = 0;
        p = 0;
        rst;
        pkt_avail <= pk;
        for (c = 0; c < 16; c++) wr(32'h4000 + 32'(c) * 4, 32'(channel_lookup_entry[c]));
        wr(32'h200, 32'h0800_1001);
        wr(32'h100, rule);
        wr(32'h0, ctl);
        frame;
        for (i = 0; i < n; i++) begin
            @(posedge clock);
            slot_tick <= 1'b1;
            @(posedge clock);
            slot_tick <= 1'b0;
            @(posedge clock);
            o = tx_out;
            if (m != 0 && i % m != 0) begin
                chk(32'(o.valid), 32'h0);
            end else if (x != 0 && p == x && map[g]) begin
                chk(32'(o[9:8]), 32'h3);
                p = 0;
                g = (g + 1) % s;
            end else begin
                chk(32'(o.valid), 32'(keep));
                if (keep) chk(32'(o[7:0]), 32'({channel_lookup_entry[p], 2'h3}));
                if (x != 0) p++;
                if (x != 0 && p == x && !map[g]) begin
                    p = 0;
                    g = (g + 1) % s;
                end
            end
        end
    endtask
    task automatic msg(input logic [4:0] t, input logic [12:0] a,
        input logic [7:0] e);
        @(posedge clock);
        req <= 1'b1;
        req_type <= t;
        req_addr <= a;
        @(posedge clock);
        req <= 1'b0;
        repeat (2) @(posedge clock);
        if (e[7]) chk(32'(rx_out), 32'({e, 2'h3}));
        else chk(32'(rx_out.valid), 32'h0);
    endtask
    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    always @(posedge clock) begin
        cyc++;
        if (cyc == 8000) begin
            n_errors++;
            summarize;
        end
    end
    initial begin
        clock = 1'b0;
        {rstn, hsel, hwrite, slot_tick, pkt_avail} = 5'h0;
        {frame_tick, rx_sync_tick, req} = 3'h0;
        {haddr, hwdata, htrans, req_type, req_addr} = '0;
        for (f = 0; f < 16; f++) channel_lookup_entry[f] = 6'(f * 5 + 7);
        rst;
        rd(32'h0, 32'h0);
        rd(32'h100, 32'h0);
        wr(32'h8000, 32'hFFFF_FFFF);
        rd(32'h8000, 32'h0);
        wr(32'h4, 32'hFFFF_FFFF);
        rd(32'h4, 32'h0);
        wr(32'h7FFC, 32'h2A);
        rd(32'h7FFC, 32'h2A);
        wr(32'h68FC, 32'h15);
        rd(32'h68FC, 32'h15);
        for (f = 0; f < 6; f++) wr(32'h200 + 32'(f) * 4, 32'h0800_1001 + f);
        for (f = 0; f < 6; f++)
            rd(32'h200 + 32'(f) * 4, 32'h0800_1001 + f);
        txrun(32'h0004_20C0, 32'h0, 1'b0, 0, 3, 3, 16'h4, 1'b1, 20);
        txrun(32'h4, 32'h0, 1'b0, 4, 0, 1, 16'h0, 1'b1, 8);
        txrun(32'h82, 32'h0, 1'b0, 2, 2, 1, 16'h0, 1'b1, 8);
        txrun(32'h100, 32'h0, 1'b0, 0, 4, 1, 16'h0, 1'b1, 8);
        txrun(32'h100, 32'h2, 1'b0, 0, 4, 1, 16'h0, 1'b0, 4);
        txrun(32'h100, 32'h2, 1'b1, 0, 4, 1, 16'h0, 1'b1, 8);
        txrun(32'h100, 32'hA, 1'b0, 0, 4, 1, 16'h0, 1'b1, 4);
        txrun(32'h405, 32'h1, 1'b0, 0, 16, 1, 16'h0, 1'b1, 32);
        rst;
        wr(32'h200, 32'h0800_1001);
        wr(32'h314, {11'h1, 13'h123, 5'h3, 3'h0});
        wr(32'h324, {11'h0, 13'h456, 5'h3, 3'h0});
        wr(32'h424, 32'h5);
        wr(32'h0, 32'h4);
        frame;
        msg(5'h3, 13'h777, 8'h00);
        msg(5'h4, 13'h123, 8'h00);
        msg(5'h3, 13'h456, 8'h89);
        msg(5'h3, 13'h456, 8'hC9);
        msg(5'h3, 13'h456, 8'h89);
        msg(5'h3, 13'h123, 8'h00);
        msg(5'h3, 13'h123, 8'hC5);
        rd(32'h4, 32'h0002_0000);
        wr(32'h4000, 32'h5);
        wr(32'h100, 32'h80);
        wr(32'h0, 32'h1);
        for (f = 0; f < 3; f++) msg(5'h0, 13'h0, 8'h00);
        msg(5'h0, 13'h0, 8'h85);
        summarize;
    end
endmodule
